//--- core/tcf_regs.svh
`ifndef TCF_REGS_SVH
`define TCF_REGS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TCF_OFF_CTRL 8'h00
`define TCF_OFF_JTHR 8'h04
`define TCF_OFF_TTHR 8'h08
`define TCF_OFF_SLEEP 8'h0c
`define TCF_OFF_TMO 8'h10
`define TCF_OFF_STAT 8'h14
`define TCF_OFF_OUT 8'h18
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define TCF_CTRL_EN 0
`define TCF_CTRL_EVT 2:1
`define TCF_CTRL_GUARD 3
`define TCF_CTRL_GRP 7:4
`define TCF_CTRL_KSH 10:8
`define TCF_CTRL_FSEL 13:12
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TCF_KSH_RST 3'h4
`define TCF_JTHR_RST 16'h0004
`define TCF_TTHR_RST 16'h0040
`define TCF_SLEEP_RST 16'h000a
`define TCF_TMO_RST 16'h0064
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TCF_CLK_NS 50
`define TCF_TICK_US 1000
`define TCF_TICK_CYC (`TCF_TICK_US * 1000 / `TCF_CLK_NS)
// ---------------------------------------------------------------
// sensors and median window
// ---------------------------------------------------------------
`define TCF_LAST 2'h3
`define TCF_MED_N 16
`define TCF_MED_MID 5'h07
`endif

//--- core/tcf_pkg.sv
package tcf_pkg;
	typedef enum logic [1:0] {
		TCF_ST_SLEEP = 2'h0,
		TCF_ST_START = 2'h1,
		TCF_ST_WAIT = 2'h2,
		TCF_ST_EVAL = 2'h3
	} tcf_state_e;
	typedef enum logic [1:0] {
		TCF_EVT_NONE = 2'h0,
		TCF_EVT_BLOCK = 2'h1,
		TCF_EVT_RELOAD = 2'h2,
		TCF_EVT_DROP = 2'h3
	} tcf_evt_e;
	typedef logic [15:0] tcf_cnt_t;
	typedef struct packed {
		tcf_state_e st;
		logic [1:0] sens;
		logic scan_req;
		logic irq_seen;
		logic evt_seen;
		logic en;
		tcf_evt_e evt;
		logic guard_en;
		logic [3:0] grp;
		logic [2:0] ksh;
		logic [1:0] fsel;
		tcf_cnt_t jthr, tthr, slp, tmo, tick_cnt, wait_cnt, tmo_cnt;
		logic tick;
		logic cont;
		logic [3:0][15:0] base;
		logic [3:0] raw_touch;
		logic [3:0] touch;
		logic rep_valid;
		logic blocked;
		logic [15:0] iir;
		logic iir_ok;
		logic [15:0] jit;
		logic jit_ok;
		logic filt_v;
		logic med_v;
		logic [15:0] med_s;
		logic [7:0] pos;
		logic pos_ok;
		logic [7:0] rescans;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tcf_top_s;
	typedef struct packed {
		logic [15:0][15:0] win;
		logic primed;
		logic upd;
		logic [15:0] med;
	} tcf_med_s;
endpackage : tcf_pkg

//--- core/tcf_med.sv
`timescale 1ns/10ps
`include "tcf_regs.svh"

module tcf_med (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic valid_in,
	input wire logic [15:0] sample_in,
	output logic [15:0] median_out
);
	tcf_pkg::tcf_med_s s_reg, s_next;
	logic [4:0] rank [`TCF_MED_N];
	logic [15:0] pick;
	logic [4:0] lt_cnt, le_cnt;

	// rank with index tie-break: every entry gets a distinct rank
	function automatic logic [4:0] f_rank(input logic [15:0][15:0] w, input int i);
		logic [4:0] r;
		r = 5'h00;
		for (int j = 0; j < `TCF_MED_N; j++)
		begin
			if (w[j] < w[i] || (w[j] == w[i] && j < i))
				r = r + 5'h01;
		end
		return r;
	endfunction : f_rank

	for (genvar i = 0; i < `TCF_MED_N; i++)
	begin : g_rank
		assign rank[i] = f_rank(s_reg.win, i);
	end

	always_comb
	begin
		pick = 16'h0000;
		for (int i = 0; i < `TCF_MED_N; i++)
		begin
			if (rank[i] == `TCF_MED_MID)
				pick = s_reg.win[i]; //RQ17
		end
	end

	always_comb
	begin
		s_next = s_reg;
		s_next.upd = 1'b0;
		if (valid_in)
		begin
			s_next.upd = 1'b1;
			s_next.primed = 1'b1;
			if (!s_reg.primed)
				s_next.win = {`TCF_MED_N{sample_in}}; //RQ18
			else
				s_next.win = {s_reg.win[14:0], sample_in}; //RQ3
		end
		if (s_reg.upd)
			s_next.med = pick; //RQ4
	end

	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign median_out = s_reg.med;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	always_comb
	begin
		lt_cnt = 5'h00;
		le_cnt = 5'h00;
		for (int i = 0; i < `TCF_MED_N; i++)
		begin
			if (s_reg.win[i] < s_reg.med)
				lt_cnt = lt_cnt + 5'h01;
			if (s_reg.win[i] <= s_reg.med)
				le_cnt = le_cnt + 5'h01;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	property p_med_shift;
		s_reg.primed && valid_in |=> s_reg.win[0] == $past(sample_in)
			&& s_reg.win[15] == $past(s_reg.win[14]);
	endproperty
	a_med_shift: assert property (p_med_shift) else $error("window not shifted"); //RQ3
	property p_med_prime;
		!s_reg.primed && valid_in |=> s_reg.win == {16{$past(sample_in)}};
	endproperty
	a_med_prime: assert property (p_med_prime) else $error("window not primed"); //RQ18
	property p_med_mid;
		s_reg.upd && !valid_in |=> lt_cnt <= 5'h07 && le_cnt >= 5'h08;
	endproperty
	a_med_mid: assert property (p_med_mid) else $error("median not lower middle"); //RQ17
endmodule : tcf_med

//--- core/tcf_top.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "tcf_regs.svh"

// Function
// RQ1 - smoothing output is (new input plus (k-1) times old output) over k
// RQ2 - coefficient sixteen weights old output by fifteen, divides by sixteen
// RQ3 - median window keeps the N newest samples, oldest dropped on write
// RQ4 - each window update orders samples and outputs the middle one
// RQ5 - median window is sixteen samples: current plus fifteen before
// RQ6 - slider filter steps to input minus/plus one beyond one, else holds
// RQ7 - raw jitter filter holds within threshold, else input pulled back by threshold
// RQ8 - during an event pattern, reports are suppressed until it clears
// RQ9 - event response may reload the baseline of the scanned sensor
// RQ10 - event response may discard the sample taken during the event
// RQ11 - host interrupt during a scan discards the count and rescans
// RQ12 - among touched buttons of the exclusive group only one is reported
// RQ13 - guard sensor active forces all real sensors inactive
// RQ14 - sleep-scan wakes each period, scans all, updates baselines, evaluates, sleeps
// RQ15 - a touch in sleep-scan enters continuous back-to-back scanning
// RQ16 - continuous scan lasts a timeout restarted by touch, then sleep-scan
// RQ17 - even window takes lower central sample; divisions truncate
// RQ18 - filter history loads from the first valid sample after reset
module tcf_top #(
	parameter int TICK_CYC = `TCF_TICK_CYC
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic raw_valid_in,
	input wire logic [15:0] raw_count_in,
	input wire logic host_irq_in,
	input wire logic event_in,
	input wire logic pos_valid_in,
	input wire logic [7:0] pos_in,
	output logic scan_req_out,
	output logic [1:0] scan_sensor_out,
	output logic [3:0] touch_out,
	output logic report_valid_out,
	output logic [15:0] iir_out,
	output logic [15:0] jitter_out,
	output logic filt_valid_out,
	output logic [15:0] median_out,
	output logic [7:0] pos_out
);
	tcf_pkg::tcf_top_s s_reg, s_next;
	logic [15:0] x;
	logic accept, feed, evt_hit, hit, apb_setup, apb_wr;
	logic [16:0] x_up, j_up, t_lim;
	logic [8:0] p_up, q_up;
	logic [23:0] iir_acc, iir_sh;
	logic [3:0] tv, g;

	assign x = raw_count_in;
	assign evt_hit = s_reg.evt_seen || event_in;
	assign accept = s_reg.st == tcf_pkg::TCF_ST_WAIT && raw_valid_in && !s_reg.irq_seen
		&& !host_irq_in && !(s_reg.evt == tcf_pkg::TCF_EVT_DROP && evt_hit); //RQ10
	assign feed = accept && s_reg.sens == s_reg.fsel;
	assign x_up = {1'b0, x} + {1'b0, s_reg.jthr};
	assign j_up = {1'b0, s_reg.jit} + {1'b0, s_reg.jthr};
	assign t_lim = {1'b0, s_reg.base[s_reg.sens]} + {1'b0, s_reg.tthr};
	assign hit = {1'b0, x} > t_lim;
	assign p_up = {1'b0, s_reg.pos} + 9'h001;
	assign q_up = {1'b0, pos_in} + 9'h001;
	// k is a power of two, so (k-1)*y is (y<<ksh)-y; all terms positive, shift truncates
	assign iir_acc = {8'h00, x} + ({8'h00, s_reg.iir} << s_reg.ksh) - {8'h00, s_reg.iir};
	assign iir_sh = iir_acc >> s_reg.ksh;
	assign apb_setup = psel_in && !penable_in;
	assign apb_wr = psel_in && penable_in && s_reg.pready && !s_reg.pslverr && pwrite_in;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		tv = s_reg.raw_touch;
		g = 4'h0;
		s_next.scan_req = 1'b0;
		s_next.rep_valid = 1'b0;
		s_next.filt_v = 1'b0;
		s_next.med_v = 1'b0;
		s_next.tick = 1'b0;
		s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
		if (s_reg.tick_cnt == 16'(TICK_CYC - 1))
		begin
			s_next.tick_cnt = 16'h0000;
			s_next.tick = 1'b1;
		end
		if (s_reg.cont && s_reg.tick)
		begin
			if (s_reg.tmo_cnt == 16'h0000)
				s_next.cont = 1'b0; //RQ16
			else
				s_next.tmo_cnt = s_reg.tmo_cnt - 16'h0001;
		end
		case (s_reg.st)
			tcf_pkg::TCF_ST_SLEEP:
			begin
				if (s_reg.en && s_reg.tick)
				begin
					if (s_reg.wait_cnt == 16'h0000)
					begin
						s_next.st = tcf_pkg::TCF_ST_START; //RQ14
						s_next.sens = 2'h0;
					end
					else
						s_next.wait_cnt = s_reg.wait_cnt - 16'h0001;
				end
			end
			tcf_pkg::TCF_ST_START:
			begin
				s_next.scan_req = 1'b1;
				s_next.irq_seen = 1'b0;
				s_next.evt_seen = 1'b0;
				s_next.st = tcf_pkg::TCF_ST_WAIT;
			end
			tcf_pkg::TCF_ST_WAIT:
			begin
				s_next.irq_seen = s_reg.irq_seen || host_irq_in;
				s_next.evt_seen = evt_hit;
				if (raw_valid_in)
				begin
					if (s_reg.irq_seen || host_irq_in)
					begin
						s_next.st = tcf_pkg::TCF_ST_START; //RQ11
						s_next.rescans = s_reg.rescans + 8'h01;
					end
					else
					begin
						if (accept)
						begin
							s_next.raw_touch[s_reg.sens] = hit;
							if (s_reg.evt == tcf_pkg::TCF_EVT_RELOAD && evt_hit)
								s_next.base[s_reg.sens] = x; //RQ9
							else if (!hit && x > s_reg.base[s_reg.sens])
								s_next.base[s_reg.sens] = s_reg.base[s_reg.sens] + 16'h0001; //RQ14
							else if (!hit && x < s_reg.base[s_reg.sens])
								s_next.base[s_reg.sens] = s_reg.base[s_reg.sens] - 16'h0001; //RQ14
						end
						s_next.sens = s_reg.sens + 2'h1;
						s_next.st = (s_reg.sens == `TCF_LAST) ? tcf_pkg::TCF_ST_EVAL
							: tcf_pkg::TCF_ST_START;
					end
				end
			end
			tcf_pkg::TCF_ST_EVAL:
			begin
				if (s_reg.guard_en && tv[3])
					tv[2:0] = 3'h0; //RQ13
				g = tv & s_reg.grp;
				tv = (tv & ~s_reg.grp) | (g & (~g + 4'h1)); //RQ12
				s_next.touch = tv;
				s_next.blocked = s_reg.evt == tcf_pkg::TCF_EVT_BLOCK && event_in; //RQ8
				s_next.rep_valid = !s_next.blocked; //RQ8
				if (|tv[2:0])
				begin
					s_next.cont = 1'b1; //RQ15
					s_next.tmo_cnt = s_reg.tmo; //RQ16
				end
				s_next.sens = 2'h0;
				if (s_next.cont)
					s_next.st = tcf_pkg::TCF_ST_START; //RQ15
				else
				begin
					s_next.st = tcf_pkg::TCF_ST_SLEEP; //RQ14
					s_next.wait_cnt = s_reg.slp;
				end
			end
			default:
				s_next.st = tcf_pkg::TCF_ST_SLEEP;
		endcase

		// filters: raw count of the selected sensor, and the slider position
		if (feed)
		begin
			s_next.filt_v = 1'b1;
			s_next.med_v = 1'b1;
			s_next.med_s = x;
			s_next.iir_ok = 1'b1;
			s_next.jit_ok = 1'b1;
			if (!s_reg.iir_ok)
				s_next.iir = x; //RQ18
			else
				s_next.iir = iir_sh[15:0]; //RQ1
			if (!s_reg.jit_ok)
				s_next.jit = x; //RQ18
			else if ({1'b0, x} > j_up)
				s_next.jit = x - s_reg.jthr; //RQ7
			else if (x_up < {1'b0, s_reg.jit})
				s_next.jit = x_up[15:0]; //RQ7
		end
		if (pos_valid_in)
		begin
			s_next.pos_ok = 1'b1;
			if (!s_reg.pos_ok)
				s_next.pos = pos_in; //RQ18
			else if ({1'b0, pos_in} > p_up)
				s_next.pos = pos_in - 8'h01; //RQ6
			else if (q_up < {1'b0, s_reg.pos})
				s_next.pos = pos_in + 8'h01; //RQ6
		end

		// apb slave: decode in setup, one-cycle access
		s_next.pready = apb_setup;
		s_next.pslverr = 1'b0;
		if (apb_setup)
		begin
			case (paddr_in)
				`TCF_OFF_CTRL: s_next.prdata = {18'h00000, s_reg.fsel, 1'b0, s_reg.ksh,
					s_reg.grp, s_reg.guard_en, s_reg.evt, s_reg.en};
				`TCF_OFF_JTHR: s_next.prdata = {16'h0000, s_reg.jthr};
				`TCF_OFF_TTHR: s_next.prdata = {16'h0000, s_reg.tthr};
				`TCF_OFF_SLEEP: s_next.prdata = {16'h0000, s_reg.slp};
				`TCF_OFF_TMO: s_next.prdata = {16'h0000, s_reg.tmo};
				`TCF_OFF_STAT: s_next.prdata = {8'h00, s_reg.rescans, 4'h0, s_reg.raw_touch,
					s_reg.touch, 2'h0, s_reg.blocked, s_reg.cont};
				`TCF_OFF_OUT: s_next.prdata = {median_out, s_reg.iir};
				default:
				begin
					s_next.prdata = 32'h0000_0000;
					s_next.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr)
		begin
			case (paddr_in)
				`TCF_OFF_CTRL:
				begin
					s_next.en = pwdata_in[`TCF_CTRL_EN];
					s_next.evt = tcf_pkg::tcf_evt_e'(pwdata_in[`TCF_CTRL_EVT]);
					s_next.guard_en = pwdata_in[`TCF_CTRL_GUARD];
					s_next.grp = pwdata_in[`TCF_CTRL_GRP];
					s_next.ksh = pwdata_in[`TCF_CTRL_KSH];
					s_next.fsel = pwdata_in[`TCF_CTRL_FSEL];
				end
				`TCF_OFF_JTHR: s_next.jthr = pwdata_in[15:0];
				`TCF_OFF_TTHR: s_next.tthr = pwdata_in[15:0];
				`TCF_OFF_SLEEP: s_next.slp = pwdata_in[15:0];
				`TCF_OFF_TMO: s_next.tmo = pwdata_in[15:0];
				default: s_next.tmo = s_next.tmo;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			s_reg <= '0;
			s_reg.ksh <= `TCF_KSH_RST;
			s_reg.jthr <= `TCF_JTHR_RST;
			s_reg.tthr <= `TCF_TTHR_RST;
			s_reg.slp <= `TCF_SLEEP_RST;
			s_reg.tmo <= `TCF_TMO_RST;
		end
		else
			s_reg <= s_next;
	end

	// ---------------------------------------------------------------
	// median and outputs
	// ---------------------------------------------------------------
	tcf_med u_med (
		.mclk_in(mclk_in),
		.arst_n_in(arst_n_in),
		.valid_in(s_reg.med_v),
		.sample_in(s_reg.med_s),
		.median_out(median_out)
	);

	assign prdata_out = s_reg.prdata;
	assign pready_out = s_reg.pready;
	assign pslverr_out = s_reg.pslverr;
	assign scan_req_out = s_reg.scan_req;
	assign scan_sensor_out = s_reg.sens;
	assign touch_out = s_reg.touch;
	assign report_valid_out = s_reg.rep_valid;
	assign iir_out = s_reg.iir;
	assign jitter_out = s_reg.jit;
	assign filt_valid_out = s_reg.filt_v;
	assign pos_out = s_reg.pos;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	property p_rescan;
		s_reg.st == tcf_pkg::TCF_ST_WAIT && raw_valid_in && (s_reg.irq_seen || host_irq_in)
			|=> s_reg.st == tcf_pkg::TCF_ST_START && s_reg.sens == $past(s_reg.sens)
			##1 scan_req_out;
	endproperty
	a_rescan: assert property (p_rescan) else $error("count not rescanned"); //RQ11
	property p_drop;
		s_reg.st == tcf_pkg::TCF_ST_WAIT && raw_valid_in && !accept && event_in
			&& s_reg.evt == tcf_pkg::TCF_EVT_DROP |=> $stable(s_reg.base) && !filt_valid_out;
	endproperty
	a_drop: assert property (p_drop) else $error("event sample used"); //RQ10
	property p_reload;
		accept && event_in && s_reg.evt == tcf_pkg::TCF_EVT_RELOAD
			|=> s_reg.base[$past(s_reg.sens)] == $past(raw_count_in);
	endproperty
	a_reload: assert property (p_reload) else $error("baseline not reloaded"); //RQ9
	property p_block;
		s_reg.st == tcf_pkg::TCF_ST_EVAL && event_in && s_reg.evt == tcf_pkg::TCF_EVT_BLOCK
			|=> !report_valid_out && s_reg.blocked;
	endproperty
	a_block: assert property (p_block) else $error("report not blocked"); //RQ8
	property p_guard;
		s_reg.st == tcf_pkg::TCF_ST_EVAL && s_reg.guard_en && s_reg.raw_touch[3]
			|=> touch_out[2:0] == 3'h0;
	endproperty
	a_guard: assert property (p_guard) else $error("real sensor active with guard"); //RQ13
	property p_group;
		report_valid_out |-> $onehot0(touch_out & s_reg.grp);
	endproperty
	a_group: assert property (p_group) else $error("two group buttons reported"); //RQ12
	property p_cont;
		s_reg.st == tcf_pkg::TCF_ST_EVAL ##1 (|touch_out[2:0])
			|-> s_reg.cont && s_reg.st == tcf_pkg::TCF_ST_START && s_reg.tmo_cnt == s_reg.tmo;
	endproperty
	a_cont: assert property (p_cont) else $error("touch left sleep-scan"); //RQ15
	property p_sleep;
		s_reg.st == tcf_pkg::TCF_ST_EVAL ##1 !s_reg.cont |-> s_reg.st == tcf_pkg::TCF_ST_SLEEP;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep after scan"); //RQ14
	property p_tmo;
		$fell(s_reg.cont) |-> $past(s_reg.tmo_cnt) == 16'h0000 && $past(s_reg.tick);
	endproperty
	a_tmo: assert property (p_tmo) else $error("early timeout"); //RQ16
	property p_iir;
		feed && s_reg.iir_ok && s_reg.ksh == 3'h4 |=> iir_out == 16'((({8'h00,
			$past(raw_count_in)} + 24'h00000f * {8'h00, $past(s_reg.iir)}) >> 4));
	endproperty
	a_iir: assert property (p_iir) else $error("smoothing wrong"); //RQ2
	property p_jit;
		feed && s_reg.jit_ok && {1'b0, x} > j_up |=> jitter_out == $past(x) - $past(s_reg.jthr)
			##1 (filt_valid_out || $stable(jitter_out));
	endproperty
	a_jit: assert property (p_jit) else $error("raw jitter wrong"); //RQ7
	property p_slide;
		pos_valid_in && s_reg.pos_ok && {1'b0, pos_in} > p_up |=> pos_out == $past(pos_in) - 8'h01;
	endproperty
	a_slide: assert property (p_slide) else $error("slider jitter wrong"); //RQ6
endmodule : tcf_top

//--- testbench/tcf_fe_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// sensing front end: one count per scan request
// ---------------------------------------------------------------
module tcf_fe_model (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic scan_req_in,
	input wire logic [1:0] sensor_in,
	input wire logic [63:0] counts_in,
	input wire logic slow_in,
	output logic raw_valid_out,
	output logic [15:0] raw_count_out
);
	int dly;
	logic [15:0] last;
	// idle bus shows the inverse of the last count, never a stale copy
	always @(posedge mclk_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			dly <= 0;
			last <= 16'h0000;
			raw_valid_out <= 1'b0;
			raw_count_out <= 16'hffff;
		end
		else if (scan_req_in)
		begin
			dly <= slow_in ? 12 : 4;
			raw_valid_out <= 1'b0;
			raw_count_out <= ~last;
		end
		else if (dly == 1)
		begin
			dly <= 0;
			raw_valid_out <= 1'b1;
			raw_count_out <= counts_in[sensor_in*16 +: 16];
			last <= counts_in[sensor_in*16 +: 16];
		end
		else
		begin
			if (dly > 1)
				dly <= dly - 1;
			raw_valid_out <= 1'b0;
			raw_count_out <= ~last;
		end
endmodule : tcf_fe_model

//--- testbench/tb.sv
`timescale 1ns/10ps
`include "tcf_regs.svh"
module tb;
	logic mclk_in, arst_n_in, psel, pen, pwr, hirq, ev, posv, rv, slow, pready, perr;
	logic sreq, rep, fv, pd;
	logic [7:0] paddr, pos, pos_o;
	logic [31:0] pwdata, prdata, lfsr;
	logic [15:0] rc, iir, jit, med;
	logic [63:0] cnt;
	logic [1:0] ssel, fvd;
	logic [3:0] touch;
	logic [15:0] win [16];
	logic [31:0] qa[$], qk[$], qf[$];
	logic [15:0] qm[$];
	logic [7:0] qp[$];
	int err_total, num_checks, taint, evs, prim, y, j, pp, c;
	int ksh_v = 4, jthr_v = 4, evt_v = 0;

	tcf_top #(.TICK_CYC(4)) i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(perr), .raw_valid_in(rv), .raw_count_in(rc), .host_irq_in(hirq),
		.event_in(ev), .pos_valid_in(posv), .pos_in(pos), .scan_req_out(sreq),
		.scan_sensor_out(ssel), .touch_out(touch), .report_valid_out(rep),
		.iir_out(iir), .jitter_out(jit), .filt_valid_out(fv), .median_out(med),
		.pos_out(pos_o));
	tcf_fe_model i_fe (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .scan_req_in(sreq),
		.sensor_in(ssel), .counts_in(cnt), .slow_in(slow), .raw_valid_out(rv),
		.raw_count_out(rc));

	initial
	begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (e !== s)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk_in);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		pen <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk_in);
			if (pready === 1'b1)
				break;
		end
		psel <= 1'b0;
		pen <= 1'b0;
		if (i == 20)
		begin
			chk("pready", 1, 0);
			end_sim;
		end
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		qa.push_back(e);
		qk.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// which 0: report pulse, 1: scan request of sensor 0
	task wt(input int which, input int n);
		int i;
		repeat (n)
		begin
			for (i = 0; i < 3000; i++)
			begin
				@(posedge mclk_in);
				if ((which == 0 && rep === 1'b1) || (which == 1 && sreq === 1'b1 && ssel === 2'h0))
					break;
			end
			if (i == 3000)
			begin
				chk("wait", which, 32'hff);
				end_sim;
			end
		end
	endtask : wt

	task automatic ref_step(input logic [15:0] x);
		logic [15:0] s [16];
		if (prim == 0)
		begin
			y = x;
			j = x;
			prim = 1;
			foreach (win[i]) win[i] = x;
		end
		else
		begin
			y = (x + ((1 << ksh_v) - 1) * y) >> ksh_v;
			if (x > j + jthr_v)
				j = x - jthr_v;
			else if (x + jthr_v < j)
				j = x + jthr_v;
			for (int i = 15; i > 0; i--) win[i] = win[i-1];
			win[0] = x;
		end
		s = win;
		s.sort();
		qf.push_back({y[15:0], j[15:0]});
		qm.push_back(s[7]);
	endtask : ref_step

	// ---------------------------------------------------------------
	// monitor: reference model and comparisons
	// ---------------------------------------------------------------
	always @(posedge mclk_in)
	begin
		if (sreq === 1'b1)
		begin
			taint = 0;
			evs = 0;
		end
		if (hirq)
			taint = 1;
		if (ev)
			evs = 1;
		if (rv && ssel === 2'h0 && taint == 0 && !(evt_v == 3 && evs == 1))
			ref_step(rc);
		fvd <= {fvd[0], fv};
		pd <= posv;
		if (fv === 1'b1)
			chk("iir and jitter", qf.size() ? qf.pop_front() : 'x, {iir, jit});
		if (fvd[1] === 1'b1)
			chk("median", qm.size() ? qm.pop_front() : 'x, med);
		if (pd === 1'b1)
			chk("slider", qp.size() ? qp.pop_front() : 'x, pos_o);
		if (psel && pen && pready === 1'b1)
		begin
			chk("pslverr", paddr > `TCF_OFF_OUT, perr);
			if (!pwr)
				chk("prdata", qa.pop_front(), prdata & qk.pop_front());
			if (pwr && paddr == `TCF_OFF_CTRL)
			begin
				ksh_v = pwdata[10:8];
				evt_v = pwdata[2:1];
			end
			if (pwr && paddr == `TCF_OFF_JTHR)
				jthr_v = pwdata[15:0];
		end
	end

	initial
	begin
		#(60000 * 50);
		chk("run time", 0, 1);
		end_sim;
	end

	initial
	begin
		{psel, pen, pwr, hirq, ev, posv, slow, paddr, pos, pwdata} = '0;
		{err_total, num_checks, pp} = '0;
		cnt = {4{16'h0800}};
		lfsr = 32'd66435;
		arst_n_in = 1'b0;
		repeat (3) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		rd(`TCF_OFF_CTRL, 32'h0000_0400, 32'hffff_ffff);
		rd(`TCF_OFF_JTHR, {16'h0, `TCF_JTHR_RST}, 32'hffff_ffff);
		rd(`TCF_OFF_TTHR, {16'h0, `TCF_TTHR_RST}, 32'hffff_ffff);
		rd(`TCF_OFF_SLEEP, {16'h0, `TCF_SLEEP_RST}, 32'hffff_ffff);
		rd(`TCF_OFF_TMO, {16'h0, `TCF_TMO_RST}, 32'hffff_ffff);
		rd(8'h1c, 32'h0, 32'hffff_ffff);
		$display("test registers done");
		pp = 100;
		for (int k = 0; k < 14; k++)
		begin
			lfsr = nxt(lfsr);
			c = (k == 0) ? 100 : 100 + lfsr[2:0] - 3;
			@(posedge mclk_in);
			posv <= 1'b1;
			pos <= c[7:0];
			if (k > 0 && c > pp + 1)
				pp = c - 1;
			else if (k > 0 && c + 1 < pp)
				pp = c + 1;
			qp.push_back(pp[7:0]);
			@(posedge mclk_in);
			posv <= 1'b0;
		end
		$display("test slider done");
		apb(1'b1, `TCF_OFF_SLEEP, 32'd20);
		apb(1'b1, `TCF_OFF_TMO, 32'd2);
		apb(1'b1, `TCF_OFF_JTHR, 32'd3);
		rd(`TCF_OFF_JTHR, 32'd3, 32'hffff_ffff);
		ev <= 1'b1;
		apb(1'b1, `TCF_OFF_CTRL, 32'h0000_0205);
		wt(0, 2);
		ev <= 1'b0;
		apb(1'b1, `TCF_OFF_CTRL, 32'h0000_0201);
		for (int k = 0; k < 12; k++)
		begin
			wt(0, 1);
			lfsr = nxt(lfsr);
			cnt[15:0] <= 16'h07d0 + lfsr[5:0];
			slow <= lfsr[9];
			if (k == 6)
				apb(1'b1, `TCF_OFF_CTRL, 32'h0000_0401);
		end
		$display("test filters done");
		wt(1, 1);
		hirq <= 1'b1;
		@(posedge mclk_in);
		hirq <= 1'b0;
		wt(0, 1);
		rd(`TCF_OFF_STAT, 32'h0001_0000, 32'h00ff_0000);
		ev <= 1'b1;
		apb(1'b1, `TCF_OFF_CTRL, 32'h0000_0407);
		wt(0, 2);
		ev <= 1'b0;
		wt(0, 2);
		$display("test interrupt and drop done");
		apb(1'b1, `TCF_OFF_CTRL, 32'h0000_0403);
		ev <= 1'b1;
		// reports are held back now, so wait for the next round to start instead
		wt(1, 1);
		c = 0;
		repeat (600)
		begin
			@(posedge mclk_in);
			c += (rep === 1'b1);
		end
		chk("blocked reports", 0, c);
		rd(`TCF_OFF_STAT, 32'h2, 32'h2);
		ev <= 1'b0;
		wt(0, 1);
		$display("test block done");
		apb(1'b1, `TCF_OFF_CTRL, 32'h0000_0469);
		cnt[63:16] <= {3{16'h0841}};
		wt(0, 2);
		chk("guard touch", 4'h8, touch);
		rd(`TCF_OFF_STAT, 32'h0000_0e80, 32'h0000_0ff0);
		cnt[63:48] <= 16'h0800;
		wt(0, 2);
		rd(`TCF_OFF_STAT, 32'h0000_0621, 32'h0000_0ff1);
		cnt[63:16] <= {3{16'h0800}};
		wt(0, 4);
		rd(`TCF_OFF_STAT, 32'h0, 32'h1);
		wt(0, 1);
		for (c = 0; c < 500; c++)
		begin
			@(posedge mclk_in);
			if (sreq === 1'b1)
				break;
		end
		chk("sleep gap", 1, c >= 80 && c <= 92);
		$display("test rules and scan modes done");
		chk("pending filter results", 0, qf.size());
		end_sim;
	end
endmodule : tb
